//--- hdl/boolean_bit_manipulation_unit.sv
/* Boolean bit manipulation unit: decodes one instruction, reads the addressed
 * word(s), computes result and flags, writes the word back under a held lock, except for compare, which writes nothing; an illegal opcode touches no memory.
 * Assumes a same-clock word memory with read data in the cycle after o_mem_rd,
 * and that no other master touches memory while o_mem_lock is high. */
`timescale 1ns/1ps

module boolean_bit_manipulation_unit (
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	input  wire bit_manip_pkg::instr_s  i_instr,
	input  wire logic                   i_instr_valid,
	output logic                        o_ready,
	input  wire logic [15:0]            i_mem_rdata,
	output logic [7:0]                  o_mem_addr,
	output logic                        o_mem_rd,
	output logic                        o_mem_wr,
	output logic [15:0]                 o_mem_wdata,
	output logic                        o_mem_lock,
	output bit_manip_pkg::flags_s       o_flags,
	output logic                        o_done,
	output logic                        o_illegal
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_SRC,
		ST_CAP_SRC,
		ST_WAIT_DST,
		ST_CAP_DST,
		ST_FINISH
	} state_e;

	state_e                 state, next_state;
	bit_manip_pkg::op_e     op, next_op;
	logic [7:0]             src_addr, next_src_addr;
	logic [7:0]             dst_addr, next_dst_addr;
	logic [3:0]             src_pos, next_src_pos;
	logic [3:0]             dst_pos, next_dst_pos;
	logic [7:0]             mask, next_mask;
	logic [7:0]             data, next_data;
	logic [15:0]            src_word, next_src_word;
	logic                   next_ready, next_mem_rd, next_mem_wr, next_mem_lock;
	logic                   next_done, next_illegal;
	logic [7:0]             next_mem_addr;
	logic [15:0]            next_mem_wdata;
	bit_manip_pkg::flags_s  next_flags;

	bit_manip_pkg::op_e     dec_op;
	bit_manip_pkg::flags_s  res_flags;
	logic [15:0]            res_word, fmask, fdata;
	logic                   res_write, sbit, dbit, rbit, one_word;

	// Two-byte forms are recognised by the low nibble before the opcode table
	always_comb
	begin
		dec_op = bit_manip_pkg::OP_NONE;
		if (i_instr.byte0[3:0] == bit_manip_pkg::NIB_BIT_CLEAR)
			dec_op = bit_manip_pkg::OP_CLEAR;
		else if (i_instr.byte0[3:0] == bit_manip_pkg::NIB_BIT_SET)
			dec_op = bit_manip_pkg::OP_SET;
		else
			unique case (i_instr.byte0)
				bit_manip_pkg::OPC_BIT_AND:      dec_op = bit_manip_pkg::OP_AND;
				bit_manip_pkg::OPC_BIT_OR:       dec_op = bit_manip_pkg::OP_OR;
				bit_manip_pkg::OPC_BIT_XOR:      dec_op = bit_manip_pkg::OP_XOR;
				bit_manip_pkg::OPC_BIT_COMPARE:  dec_op = bit_manip_pkg::OP_COMPARE;
				bit_manip_pkg::OPC_BIT_COPY:     dec_op = bit_manip_pkg::OP_COPY;
				bit_manip_pkg::OPC_BIT_COPY_INV: dec_op = bit_manip_pkg::OP_COPY_INV;
				bit_manip_pkg::OPC_LOAD_HIGH:    dec_op = bit_manip_pkg::OP_LOAD_HIGH;
				bit_manip_pkg::OPC_LOAD_LOW:     dec_op = bit_manip_pkg::OP_LOAD_LOW;
				default:                         dec_op = bit_manip_pkg::OP_NONE;
			endcase
		one_word = dec_op inside {bit_manip_pkg::OP_CLEAR, bit_manip_pkg::OP_SET,
			bit_manip_pkg::OP_LOAD_HIGH, bit_manip_pkg::OP_LOAD_LOW};
	end

	// Result and flags from the destination word as it arrives
	always_comb
	begin
		sbit      = src_word[src_pos];
		dbit      = i_mem_rdata[dst_pos];
		rbit      = dbit;
		res_write = 1'b1;
		res_flags = bit_manip_pkg::FLAGS_RESET;
		fmask = (op == bit_manip_pkg::OP_LOAD_HIGH) ? {mask, 8'h00} : {8'h00, mask};
		fdata = (op == bit_manip_pkg::OP_LOAD_HIGH) ? {data, 8'h00} : {8'h00, data};
		res_word = (i_mem_rdata & ~fmask) | (fdata & fmask);
		unique case (op)
			bit_manip_pkg::OP_AND:      rbit = dbit & sbit;
			bit_manip_pkg::OP_OR:       rbit = dbit | sbit;
			bit_manip_pkg::OP_XOR:      rbit = dbit ^ sbit;
			bit_manip_pkg::OP_COMPARE:  res_write = 1'b0;
			bit_manip_pkg::OP_CLEAR:    rbit = 1'b0;
			bit_manip_pkg::OP_SET:      rbit = 1'b1;
			bit_manip_pkg::OP_COPY:     rbit = sbit;
			bit_manip_pkg::OP_COPY_INV: rbit = ~sbit;
			bit_manip_pkg::OP_LOAD_HIGH, bit_manip_pkg::OP_LOAD_LOW: rbit = dbit;
			bit_manip_pkg::OP_NONE:     res_write = 1'b0;
		endcase
		if (op != bit_manip_pkg::OP_LOAD_HIGH && op != bit_manip_pkg::OP_LOAD_LOW)
		begin
			res_word          = i_mem_rdata;
			res_word[dst_pos] = rbit;
		end
		unique case (op)
			bit_manip_pkg::OP_AND,
			bit_manip_pkg::OP_OR,
			bit_manip_pkg::OP_XOR,
			bit_manip_pkg::OP_COMPARE:
			begin
				res_flags.z = ~(dbit | sbit);
				res_flags.v = dbit | sbit;
				res_flags.c = dbit & sbit;
				res_flags.n = dbit ^ sbit;
			end
			bit_manip_pkg::OP_CLEAR,
			bit_manip_pkg::OP_SET:
			begin
				res_flags.z = ~dbit;
				res_flags.n = dbit;
			end
			bit_manip_pkg::OP_COPY,
			bit_manip_pkg::OP_COPY_INV:
			begin
				res_flags.z = ~sbit;
				res_flags.n = sbit;
			end
			bit_manip_pkg::OP_LOAD_HIGH,
			bit_manip_pkg::OP_LOAD_LOW:
			begin
				res_flags.z = (res_word == bit_manip_pkg::WORD_RESET);
				res_flags.n = res_word[bit_manip_pkg::WORD_W-1];
			end
			bit_manip_pkg::OP_NONE:     res_flags = bit_manip_pkg::FLAGS_RESET;
		endcase
	end

	always_comb
	begin
		next_state     = state;
		next_op        = op;
		next_src_addr  = src_addr;
		next_dst_addr  = dst_addr;
		next_src_pos   = src_pos;
		next_dst_pos   = dst_pos;
		next_mask      = mask;
		next_data      = data;
		next_src_word  = src_word;
		next_ready     = o_ready;
		next_mem_addr  = o_mem_addr;
		next_mem_rd    = 1'b0;
		next_mem_wr    = 1'b0;
		next_mem_wdata = o_mem_wdata;
		next_mem_lock  = o_mem_lock;
		next_flags     = o_flags;
		next_done      = 1'b0;
		next_illegal   = 1'b0;
		unique case (state)
			ST_IDLE:
			begin
				if (i_instr_valid && o_ready)
				begin
					next_op       = dec_op;
					next_src_addr = i_instr.byte1;
					next_dst_addr = i_instr.byte2;
					next_src_pos  = i_instr.byte3[7:4];
					next_dst_pos  = i_instr.byte3[3:0];
					next_mask     = i_instr.byte3;
					next_data     = i_instr.byte2;
					if (dec_op == bit_manip_pkg::OP_LOAD_LOW)
					begin
						next_mask = i_instr.byte2;
						next_data = i_instr.byte3;
					end
					if (one_word)
						next_dst_addr = i_instr.byte1;
					if (dec_op == bit_manip_pkg::OP_CLEAR || dec_op == bit_manip_pkg::OP_SET)
						next_dst_pos = i_instr.byte0[7:4];
					next_ready = 1'b0;
					if (dec_op == bit_manip_pkg::OP_NONE)
					begin
						next_illegal = 1'b1;
						next_done    = 1'b1;
						next_state   = ST_FINISH;
					end
					else
					begin
						next_mem_rd   = 1'b1;
						next_mem_lock = 1'b1;
						if (one_word)
						begin
							next_mem_addr = next_dst_addr;
							next_state    = ST_WAIT_DST;
						end
						else
						begin
							next_mem_addr = i_instr.byte1;
							next_state    = ST_WAIT_SRC;
						end
					end
				end
			end
			ST_WAIT_SRC:
			begin
				next_mem_rd   = 1'b1;
				next_mem_addr = dst_addr;
				next_state    = ST_CAP_SRC;
			end
			ST_CAP_SRC:
			begin
				next_src_word = i_mem_rdata;
				next_state    = ST_CAP_DST;
			end
			ST_WAIT_DST: next_state = ST_CAP_DST;
			ST_CAP_DST:
			begin
				next_mem_wr    = res_write;
				next_mem_wdata = res_word;
				next_mem_addr  = dst_addr;
				next_flags     = res_flags;
				next_done      = 1'b1;
				next_state     = ST_FINISH;
			end
			ST_FINISH:
			begin
				// Lock drops only after the write cycle has been presented
				next_mem_lock = 1'b0;
				next_ready    = 1'b1;
				next_state    = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state       <= ST_IDLE;
			op          <= bit_manip_pkg::OP_NONE;
			src_addr    <= bit_manip_pkg::BYTE_RESET;
			dst_addr    <= bit_manip_pkg::BYTE_RESET;
			src_pos     <= bit_manip_pkg::POS_RESET;
			dst_pos     <= bit_manip_pkg::POS_RESET;
			mask        <= bit_manip_pkg::BYTE_RESET;
			data        <= bit_manip_pkg::BYTE_RESET;
			src_word    <= bit_manip_pkg::WORD_RESET;
			o_ready     <= 1'b1;
			o_mem_addr  <= bit_manip_pkg::BYTE_RESET;
			o_mem_rd    <= 1'b0;
			o_mem_wr    <= 1'b0;
			o_mem_wdata <= bit_manip_pkg::WORD_RESET;
			o_mem_lock  <= 1'b0;
			o_flags     <= bit_manip_pkg::FLAGS_RESET;
			o_done      <= 1'b0;
			o_illegal   <= 1'b0;
		end
		else
		begin
			state       <= next_state;
			op          <= next_op;
			src_addr    <= next_src_addr;
			dst_addr    <= next_dst_addr;
			src_pos     <= next_src_pos;
			dst_pos     <= next_dst_pos;
			mask        <= next_mask;
			data        <= next_data;
			src_word    <= next_src_word;
			o_ready     <= next_ready;
			o_mem_addr  <= next_mem_addr;
			o_mem_rd    <= next_mem_rd;
			o_mem_wr    <= next_mem_wr;
			o_mem_wdata <= next_mem_wdata;
			o_mem_lock  <= next_mem_lock;
			o_flags     <= next_flags;
			o_done      <= next_done;
			o_illegal   <= next_illegal;
		end
	end

endmodule : boolean_bit_manipulation_unit

//--- hdl/bit_manip_pkg.sv
/*
 * Package for the boolean bit manipulation unit: opcode bytes, operation
 * kinds, instruction and flag carriers, reset values.
 * Assumes an instruction arrives as four bytes, first byte in byte0.
 */
package bit_manip_pkg;

	localparam logic [7:0] OPC_BIT_AND      = 8'h6A;
	localparam logic [7:0] OPC_BIT_OR       = 8'h5A;
	localparam logic [7:0] OPC_BIT_XOR      = 8'h7A;
	localparam logic [7:0] OPC_BIT_COMPARE  = 8'h2A;
	localparam logic [7:0] OPC_BIT_COPY     = 8'h4A;
	localparam logic [7:0] OPC_BIT_COPY_INV = 8'h3A;
	localparam logic [7:0] OPC_LOAD_HIGH    = 8'h1A;
	localparam logic [7:0] OPC_LOAD_LOW     = 8'h0A;
	localparam logic [3:0] NIB_BIT_CLEAR    = 4'hE;
	localparam logic [3:0] NIB_BIT_SET      = 4'hF;

	localparam int         WORD_W           = 16;
	localparam int         BYTE_W           = 8;
	localparam logic [7:0] BYTE_RESET       = 8'h00;
	localparam logic [3:0] POS_RESET        = 4'h0;
	localparam logic [15:0] WORD_RESET      = 16'h0000;

	typedef enum logic [3:0] {
		OP_NONE,
		OP_AND,
		OP_OR,
		OP_XOR,
		OP_COMPARE,
		OP_CLEAR,
		OP_SET,
		OP_COPY,
		OP_COPY_INV,
		OP_LOAD_HIGH,
		OP_LOAD_LOW
	} op_e;

	typedef struct packed {
		logic [7:0] byte0;
		logic [7:0] byte1;
		logic [7:0] byte2;
		logic [7:0] byte3;
	} instr_s;

	typedef struct packed {
		logic e;
		logic z;
		logic v;
		logic c;
		logic n;
	} flags_s;

	localparam flags_s FLAGS_RESET = '{e: 1'b0, z: 1'b0, v: 1'b0, c: 1'b0, n: 1'b0};

endpackage : bit_manip_pkg

//--- verification/boolean_bit_manipulation_checker.sv
/* Port checker for the bit unit.
   Assumes a bind to the unit's top module. */
`timescale 1ns/1ps
module boolean_bit_manipulation_checker (
	input wire logic                  i_clk,
	input wire logic                  i_rst,
	input wire bit_manip_pkg::instr_s i_instr,
	input wire logic                  i_instr_valid,
	input wire logic                  o_ready,
	input wire logic [15:0]           i_mem_rdata,
	input wire logic [7:0]            o_mem_addr,
	input wire logic                  o_mem_rd,
	input wire logic                  o_mem_wr,
	input wire logic [15:0]           o_mem_wdata,
	input wire logic                  o_mem_lock,
	input wire bit_manip_pkg::flags_s o_flags,
	input wire logic                  o_done,
	input wire logic                  o_illegal
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	wire logic       take = i_instr_valid && o_ready;
	wire logic [7:0] op   = i_instr.byte0;
	// Source read, then destination read, then the answer
	sequence pair_walk;
		##1 (o_mem_rd && o_mem_lock && o_mem_addr == $past(i_instr.byte1))
		##1 (o_mem_rd && o_mem_addr == $past(i_instr.byte2, 2)) ##1 !o_mem_rd ##1 o_done;
	endsequence
	and_walk_a: assert property (take && op == 8'h6A |-> pair_walk ##0 o_mem_wr)
		else $error("bit and walk wrong");
	cmp_flags_a: assert property (take && op == 8'h2A |-> pair_walk ##0 (!o_mem_wr &&
		o_flags.v == !o_flags.z && o_flags.n == (o_flags.v && !o_flags.c)))
		else $error("compare wrote or bad flags");
	copy_flags_a: assert property (take && (op == 8'h4A || op == 8'h3A) |-> pair_walk ##0
		(o_mem_wr && o_flags.z == !o_flags.n && !o_flags.v && !o_flags.c))
		else $error("copy flags wrong");
	// One word read under lock, then write and answer together
	sequence word_walk;
		##1 (o_mem_rd && o_mem_lock && o_mem_addr == $past(i_instr.byte1))
		##1 !o_mem_rd ##1 (o_done && o_mem_wr);
	endsequence
	set_bit_a: assert property (take && op[3:0] == 4'hF |-> word_walk ##0
		(o_mem_wdata[$past(op[7:4], 3)] && o_flags.z == !o_flags.n && !o_flags.v))
		else $error("bit set wrong");
	clear_bit_a: assert property (take && op[3:0] == 4'hE |-> word_walk ##0
		(!o_mem_wdata[$past(op[7:4], 3)] && o_flags.z == !o_flags.n && !o_flags.c))
		else $error("bit clear wrong");
	ready_back_a: assert property (o_done |=> (o_ready && !o_mem_lock))
		else $error("ready or lock not restored");
	load_flags_a: assert property (take && (op == 8'h1A || op == 8'h0A) |-> ##3 (o_done &&
		o_flags.z == (o_mem_wdata == 16'h0000) && o_flags.n == o_mem_wdata[15] && !o_flags.v))
		else $error("byte load flags wrong");
	end_clear_a: assert property (o_done && !o_illegal |-> !o_flags.e)
		else $error("end flag set");
	lock_write_a: assert property (o_mem_wr |-> o_mem_lock && $past(o_mem_lock, 2))
		else $error("write outside lock");
endmodule : boolean_bit_manipulation_checker

//--- verification/boolean_bit_manipulation_unit_test.sv
/* Bench for the bit unit: word memory, queued expectations, monitor.
   Assumes one-cycle read latency and one done pulse per instruction. */
`timescale 1ns/1ps
module boolean_bit_manipulation_unit_test;
	typedef struct packed {
		bit_manip_pkg::flags_s f;
		logic                  w;
		logic [7:0]            a;
		logic [15:0]           d;
		logic                  il;
	} exp_s;
	logic                  i_clk = 1'b0, i_rst = 1'b1, i_instr_valid = 1'b0, pend = 1'b0;
	bit_manip_pkg::instr_s i_instr = '0;
	logic [15:0]           i_mem_rdata = 16'h0000, o_mem_wdata, mem [256], rm [256];
	logic                  o_ready, o_mem_rd, o_mem_wr, o_mem_lock, o_done, o_illegal;
	logic [7:0]            o_mem_addr, paddr = 8'h00;
	bit_manip_pkg::flags_s o_flags, ef = '0;
	exp_s                  q [$], me;
	int                    err_count = 0, cmp_count = 0, seed = 60864;
	logic [7:0]            ops [9] = '{8'h6A, 8'h5A, 8'h7A, 8'h2A, 8'h4A, 8'h3A, 8'h1A, 8'h0A, 8'h8A};
	boolean_bit_manipulation_unit u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_instr(i_instr),
		.i_instr_valid(i_instr_valid), .o_ready(o_ready), .i_mem_rdata(i_mem_rdata),
		.o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
		.o_mem_wdata(o_mem_wdata), .o_mem_lock(o_mem_lock), .o_flags(o_flags),
		.o_done(o_done), .o_illegal(o_illegal));
	always #12.5 i_clk = ~i_clk;
	always @(posedge i_clk)
	begin
		pend <= o_mem_rd;
		paddr <= o_mem_addr;
		if (o_mem_wr === 1'b1)
			mem[o_mem_addr] <= o_mem_wdata;
	end
	// Stale data is inverted so a late read cannot match by chance
	always @(negedge i_clk)
		i_mem_rdata <= pend ? mem[paddr] : ~i_mem_rdata;
	task automatic chk_v(input logic [15:0] g, input logic [15:0] x);
		cmp_count++;
		if (g !== x)
		begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, x);
		end
	endtask : chk_v
	task automatic chk_f(input bit_manip_pkg::flags_s g, input bit_manip_pkg::flags_s x);
		cmp_count++;
		if (g !== x)
		begin
			err_count++;
			$display("[ERR] %0t flags got %h exp %h", $time, g, x);
		end
	endtask : chk_f
	task automatic test_done;
		$display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	always @(posedge i_clk)
	begin
		if (o_done === 1'b1 && q.size() == 0)
			chk_v(o_done, 1'b0);
		else if (o_done === 1'b1)
		begin
			me = q.pop_front();
			chk_f(o_flags, me.f);
			chk_v(o_illegal, me.il);
			chk_v(o_mem_wr, me.w);
			if (me.w)
			begin
				chk_v(o_mem_addr, me.a);
				chk_v(o_mem_wdata, me.d);
			end
		end
	end
	task automatic issue(input bit_manip_pkg::instr_s i);
		exp_s        e;
		logic        s, d;
		logic [7:0]  m, v;
		logic [15:0] w;
		int          n;
		e = '{ef, 1'b0, 8'h00, 16'h0000, 1'b1};
		if (i.byte0[3:0] >= 4'hE)
		begin
			w = rm[i.byte1];
			s = w[i.byte0[7:4]];
			w[i.byte0[7:4]] = i.byte0[0];
			e = '{{1'b0, !s, 1'b0, 1'b0, s}, 1'b1, i.byte1, w, 1'b0};
		end
		else if (i.byte0 == 8'h1A || i.byte0 == 8'h0A)
		begin
			w = rm[i.byte1];
			m = i.byte0[4] ? i.byte3 : i.byte2;
			v = i.byte0[4] ? i.byte2 : i.byte3;
			if (i.byte0[4])
				w[15:8] = (w[15:8] & ~m) | (v & m);
			else
				w[7:0] = (w[7:0] & ~m) | (v & m);
			e = '{{1'b0, w == 16'h0000, 1'b0, 1'b0, w[15]}, 1'b1, i.byte1, w, 1'b0};
		end
		else if (i.byte0 != 8'h8A)
		begin
			w = rm[i.byte2];
			s = rm[i.byte1][i.byte3[7:4]];
			d = w[i.byte3[3:0]];
			e = '{{1'b0, !(s | d), s | d, s & d, s ^ d}, i.byte0 != 8'h2A, i.byte2, w, 1'b0};
			case (i.byte0)
				8'h6A: w[i.byte3[3:0]] = s & d;
				8'h5A: w[i.byte3[3:0]] = s | d;
				8'h7A: w[i.byte3[3:0]] = s ^ d;
				8'h4A: w[i.byte3[3:0]] = s;
				8'h3A: w[i.byte3[3:0]] = !s;
				default: ;
			endcase
			if (i.byte0 == 8'h4A || i.byte0 == 8'h3A)
				e.f = {1'b0, !s, 1'b0, 1'b0, s};
			e.d = w;
		end
		if (e.w)
			rm[e.a] = e.d;
		ef = e.f;
		q.push_back(e);
		for (n = 0; o_ready !== 1'b1 && n < 20; n++)
			@(negedge i_clk);
		if (n == 20)
		begin
			err_count++;
			test_done();
		end
		i_instr = i;
		i_instr_valid = 1'b1;
		@(negedge i_clk);
		i_instr_valid = 1'b0;
	endtask : issue
	initial
	begin
		bit_manip_pkg::instr_s r;
		for (int k = 0; k < 256; k++)
			mem[k] = 16'($random(seed));
		rm = mem;
		repeat (5) @(negedge i_clk);
		chk_v({o_ready, o_mem_rd, o_mem_wr, o_mem_lock, o_done, o_illegal}, 16'h0020);
		chk_f(o_flags, '0);
		i_rst = 1'b0;
		$display("Test reset values done");
		// Few word addresses, so source and destination often share a word
		for (int k = 0; k < 330; k++)
		begin
			r = bit_manip_pkg::instr_s'($random(seed));
			r.byte1[7:2] = 6'h00;
			r.byte2[7:2] = 6'h00;
			if (k % 11 < 9)
				r.byte0 = ops[k % 11];
			else
				r.byte0[3:0] = (k % 11 == 9) ? 4'hE : 4'hF;
			issue(r);
		end
		repeat (8) @(negedge i_clk);
		chk_v(16'(q.size()), 16'h0000);
		$display("Test random instructions done");
		test_done();
	end
endmodule : boolean_bit_manipulation_unit_test
bind boolean_bit_manipulation_unit boolean_bit_manipulation_checker u_chk (.i_clk(i_clk),
	.i_rst(i_rst), .i_instr(i_instr), .i_instr_valid(i_instr_valid), .o_ready(o_ready),
	.i_mem_rdata(i_mem_rdata), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
	.o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .o_mem_lock(o_mem_lock),
	.o_flags(o_flags), .o_done(o_done), .o_illegal(o_illegal));
